/* dv/psu_smbus_slave_with_eeprom_bench.sv */
// Purpose: self-checking bench of the supply management port
// Assumes: shortened time-out and programming counts
// Notes:   expected values queued, compared by a watcher
`timescale 1ns/1ps
module psu_smbus_slave_with_eeprom_bench;
  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, gotVal;
  logic        sclOut, sclDriveN, sdaOut, sdaDriveN, sclH, sdaH, ack;
  logic        outputOnRequestN, mainOutput, faultAlertN;
  logic [1:0]  sel;
  logic [7:0]  ctrlA, memA, dat, loc, b;
  int          failures, num_checks;
  logic [31:0] expQ[$];
  event        gotEv;
  wire         sclWire = sclH & (sclDriveN | sclOut);
  wire         sdaWire = sdaH & (sdaDriveN | sdaOut);
  psu_mgmt_port #(.TIMEOUT_CYC(200), .PROG_CYC(100)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclIn(sclWire), .sclOut(sclOut),
    .sclDriveN(sclDriveN), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaDriveN(sdaDriveN), .outputOnRequestN(outputOnRequestN),
    .addressSelectPin(sel), .mainOutput(mainOutput),
    .faultAlertN(faultAlertN));
  smbus_host_model host_u (.sclWire(sclWire), .sdaWire(sdaWire),
    .sclH(sclH), .sdaH(sdaH));
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic compareWord(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask : compareWord
  task automatic note(input logic [31:0] e);
    expQ.push_back(e);
  endtask : note
  task automatic post(input logic [31:0] g);
    gotVal = g;
    ->gotEv;
  endtask : post
  always @(gotEv) compareWord(expQ.pop_front(), gotVal);
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Error flag folded into bit 31, no register uses it
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    logic [31:0] g;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    g = {pslverr, prdata[30:0]};
    psel <= 1'b0;
    penable <= 1'b0;
    if (!w) post(g);
  endtask : apb
  task automatic pin(input logic e, input logic g);
    note({31'h0, e});
    post({31'h0, g});
  endtask : pin
  task automatic wr(input logic [7:0] a, b1, b2, input int n, input logic e);
    host_u.start();
    host_u.sendByte(a, ack);
    pin(e, ack);
    if (n > 0) host_u.sendByte(b1, ack);
    if (n > 1) host_u.sendByte(b2, ack);
    host_u.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic useLoc,
                    input logic [7:0] l, e);
    host_u.start();
    if (useLoc) begin
      host_u.sendByte(a, ack);
      host_u.sendByte(l, ack);
      host_u.start();
    end
    host_u.sendByte(a | 8'h01, ack);
    host_u.readByte(b);
    host_u.stop();
    note({24'h0, e});
    post({24'h0, b});
  endtask : rd
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset = 1'b1;
    outputOnRequestN = 1'b1;
    void'($urandom(32'haf7d));
    sel = 2'($urandom);
    dat = 8'($urandom);
    loc = 8'($urandom);
    ctrlA = 8'hB0 + {5'h0, sel, 1'b0};
    memA = 8'hA0 + {5'h0, sel, 1'b0};
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
    note(32'h44 | {27'h0, sel, 3'h0});
    apb(1'b0, 12'h004, 32'h0);
    sel <= ~sel;
    note(32'h8000_0000);
    apb(1'b0, 12'h00C, 32'h0);
    outputOnRequestN <= 1'b0;
    repeat (5) @(posedge clk_sys);
    pin(1'b1, mainOutput);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge clk_sys);
    pin(1'b0, faultAlertN);
    note(32'h4);
    apb(1'b0, 12'h008, 32'h0);
    outputOnRequestN <= 1'b1;
    repeat (5) @(posedge clk_sys);
    pin(1'b0, mainOutput);
    outputOnRequestN <= 1'b0;
    repeat (5) @(posedge clk_sys);
    pin(1'b1, faultAlertN);
    apb(1'b1, 12'h000, 32'h2);
    repeat (2) @(posedge clk_sys);
    pin(1'b0, faultAlertN);
    rd(8'h18, 1'b0, 8'h0, 8'h02);
    apb(1'b1, 12'h000, 32'h0);
    wr(8'h19, 8'h0, 8'h0, 0, 1'b0);
    wr(8'hB8, 8'h0, 8'h0, 0, 1'b0);
    wr(ctrlA, 8'hA5, 8'h0, 1, 1'b1);
    wr(memA, loc, dat, 2, 1'b1);
    wr(memA, 8'h0, 8'h0, 0, 1'b0);
    repeat (120) @(posedge clk_sys);
    rd(memA, 1'b1, loc, dat);
    wr(ctrlA, 8'h5A, 8'h0, 1, 1'b1);
    wr(memA, loc, ~dat, 2, 1'b1);
    repeat (120) @(posedge clk_sys);
    rd(memA, 1'b1, loc, dat);
    host_u.start();
    host_u.sendBits(8'hFF, 4);
    wr(ctrlA, 8'h00, 8'h0, 1, 1'b1);
    host_u.start();
    host_u.sendBits(ctrlA, 8);
    #2000;
    pin(1'b1, sdaDriveN);
    host_u.stop();
    wr(ctrlA, 8'h00, 8'h0, 1, 1'b1);
    final_report();
  end
endmodule : psu_smbus_slave_with_eeprom_bench

/* dv/smbus_host_model.sv */
// Purpose: behavioural SMBus host for the management port
// Assumes: open-drain wires resolved by the bench, pull-ups there
// Notes:   SCL stands high between frames, 64 ns bit period
`timescale 1ns/1ps
module smbus_host_model (
  // Resolved wire levels
  input  wire logic sclWire,
  input  wire logic sdaWire,
  // Host pulls, high = released
  output logic      sclH,
  output logic      sdaH
);
  initial begin
    sclH = 1'b1;
    sdaH = 1'b1;
  end
  // ----------------------------------------------------------------
  // Bit and frame level
  // ----------------------------------------------------------------
  task automatic xfer(input logic bv, output logic r);
    #16 sdaH = bv;
    #16 sclH = 1'b1;
    // Poll on the bit grid so no pin moves on a clk_sys edge
    while (sclWire !== 1'b1) #8;
    #24 r = sdaWire;
    #8 sclH = 1'b0;
  endtask : xfer
  task automatic start();
    // Land 2 ns after a clk_sys edge, edges sit at 4 ns mod 8
    #(16 + (14 - $time % 8) % 8) sdaH = 1'b1;
    #16 sclH = 1'b1;
    #32 sdaH = 1'b0;
    #32 sclH = 1'b0;
  endtask : start
  task automatic stop();
    #16 sdaH = 1'b0;
    #16 sclH = 1'b1;
    #32 sdaH = 1'b1;
    #32;
  endtask : stop
  // Partial bytes let a Start land mid-byte
  task automatic sendBits(input logic [7:0] v, input int n);
    logic r;
    for (int i = 0; i < n; i++) xfer(v[7-i], r);
  endtask : sendBits
  task automatic sendByte(input logic [7:0] v, output logic a);
    logic r;
    sendBits(v, 8);
    xfer(1'b1, r);
    a = !r;
  endtask : sendByte
  // Single byte read, always NACKed
  task automatic readByte(output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, r);
      d = {d[6:0], r};
    end
    xfer(1'b1, r);
  endtask : readByte
endmodule : smbus_host_model

/* rtl/pin_sync.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : pin_sync

/* rtl/psu_mgmt_map.svh */
// Purpose: constants of the supply management port
// Assumes: clk_sys at 125 MHz
// Notes:   times kept in own units, cycle counts derived from them
`ifndef PSU_MGMT_MAP_SVH
`define PSU_MGMT_MAP_SVH
`define CLK_KHZ          125000
`define STRETCH_LIMIT_US 1000
`define STRETCH_LIMIT_CYC (`STRETCH_LIMIT_US * `CLK_KHZ / 1000)
`define TIMEOUT_MS       25
`define TIMEOUT_CYC      (`TIMEOUT_MS * `CLK_KHZ + 1)
`define RECOVERY_MS      10
`define RECOVERY_CYC     (`RECOVERY_MS * `CLK_KHZ)
`define PROG_MS          5
`define PROG_CYC         (`PROG_MS * `CLK_KHZ)
`define STRETCH_CYC      8
`define CTRL_ADDR_BASE   8'hB0
`define EEP_ADDR_BASE    8'hA0
`define ARA_BYTE         8'h19
`define ADDR_SEL_OPEN    2'h3
`define CMD_WP_OFF       8'hA5
`define CMD_WP_ON        8'h5A
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define REG_ALERT        12'h008
`define CTRL_SHUT_BIT    0
`define CTRL_WARN_BIT    1
`define CTRL_RESET       2'h0
`define WP_RESET         1'b1
`define ST_MAIN_BIT      0
`define ST_FAULT_BIT     1
`define ST_WP_BIT        2
`define ST_SEL_LSB       3
`define ST_BUSY_BIT      5
`define ST_SAMPLED_BIT   6
`endif

/* rtl/psu_mgmt_pkg.sv */
// Purpose: types of the supply management port
// Assumes: constants come from psu_mgmt_map.svh
// Notes:   none
package psu_mgmt_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_TXACK, S_IGNORE
  } busState_t;
  typedef enum logic [1:0] {
    TGT_NONE, TGT_CTRL, TGT_EEP, TGT_ARA
  } target_t;
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       onReqN;
    logic [1:0] sel;
  } pinSample_t;
endpackage : psu_mgmt_pkg

/* rtl/psu_mgmt_port.sv */
// Purpose: SMBus target with user memory and APB status
// Assumes: SCL sampled by clk_sys, far below its rate
// Notes:   open-drain pins, drive enable active low
`timescale 1ns/1ps
`include "psu_mgmt_map.svh"
module psu_mgmt_port #(
  parameter int unsigned TIMEOUT_CYC = `TIMEOUT_CYC,
  parameter int unsigned PROG_CYC    = `PROG_CYC,
  parameter int unsigned STRETCH_CYC = `STRETCH_CYC,
  parameter int unsigned MEM_DEPTH   = 256
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // SMBus pins
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclDriveN,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaDriveN,
  // Supply control
  input  wire logic        outputOnRequestN,
  input  wire logic [1:0]  addressSelectPin,
  output logic             mainOutput,
  output logic             faultAlertN
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int PW = $clog2(PROG_CYC + 1);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int STR_BOUND = 9;

  psu_mgmt_pkg::pinSample_t pins;
  psu_mgmt_pkg::busState_t  state, next_state;
  psu_mgmt_pkg::target_t    target, next_target;
  logic [7:0]    mem [MEM_DEPTH];
  logic          sclPrev, sdaPrev, start, stop, sclRise, sclFall;
  logic [3:0]    bitCnt, next_bitCnt;
  logic [7:0]    shiftIn, next_shiftIn, txShift, next_txShift;
  logic [7:0]    wrData, next_wrData, statusByte, rdByte;
  logic [AW-1:0] pointer, next_pointer;
  logic [1:0]    byteIdx, next_byteIdx;
  logic          rw, next_rw, wrPending, next_wrPending;
  logic          wpActive, next_wpActive, commit;
  logic          next_sdaDriveN, next_sclDriveN;
  logic [3:0]    stretchCnt, next_stretchCnt;
  logic [TW-1:0] lowCnt, next_lowCnt;
  logic [PW-1:0] progCnt, next_progCnt;
  logic          progBusy;
  logic [1:0]    ctrl, next_ctrl, sampleCnt, next_sampleCnt;
  logic [1:0]    addrSel, next_addrSel;
  logic          addrSampled, next_addrSampled;
  logic          faultLatched, next_faultLatched;
  logic          onReqPrev, evShut, evWarn;
  logic [7:0]    ctrlAddr, eepAddr;
  logic [31:0]   rdMux, next_prdata;
  logic          mapped, next_pready, next_pslverr;

  // ----------------------------------------
  // Pin sampling and bus conditions
  // ----------------------------------------
  pin_sync #(.W(5)) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d       ({sclIn, sdaIn, outputOnRequestN, addressSelectPin}),
    .q       (pins)
  );

  // 125 MHz oversamples a 100 kbps clock many times over
  assign sclRise = pins.scl & ~sclPrev;
  assign sclFall = ~pins.scl & sclPrev;
  assign start = pins.scl & sclPrev & sdaPrev & ~pins.sda;
  assign stop  = pins.scl & sclPrev & ~sdaPrev & pins.sda;
  assign evShut = ctrl[`CTRL_SHUT_BIT];
  assign evWarn = ctrl[`CTRL_WARN_BIT];
  assign statusByte = {5'h00, faultLatched, evWarn, evShut};
  assign progBusy = progCnt != '0;
  // Memory pair sits a fixed 0x10 below the controller
  assign ctrlAddr = `CTRL_ADDR_BASE + {5'h00, addrSel, 1'b0};
  assign eepAddr  = `EEP_ADDR_BASE + {5'h00, addrSel, 1'b0};
  assign rdByte = (target == psu_mgmt_pkg::TGT_EEP) ? mem[pointer]
                                                    : statusByte;

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  always_comb begin
    next_state      = state;
    next_target     = target;
    next_bitCnt     = bitCnt;
    next_shiftIn    = shiftIn;
    next_txShift    = txShift;
    next_wrData     = wrData;
    next_pointer    = pointer;
    next_byteIdx    = byteIdx;
    next_rw         = rw;
    next_wrPending  = wrPending;
    next_wpActive   = wpActive;
    next_sdaDriveN  = sdaDriveN;
    next_sclDriveN  = sclDriveN;
    next_stretchCnt = stretchCnt;
    next_progCnt    = progBusy ? progCnt - 1'b1 : progCnt;
    commit          = 1'b0;
    if (state == psu_mgmt_pkg::S_IDLE || pins.scl) begin
      next_lowCnt = '0;
    end else begin
      next_lowCnt = lowCnt + 1'b1;
    end
    if (!sclDriveN) begin
      // Stretch is a short fixed hold, far inside the limit
      next_stretchCnt = stretchCnt + 1'b1;
      if (stretchCnt == 4'(STRETCH_CYC - 1)) begin
        next_sclDriveN = 1'b1;
      end
    end
    if (start) begin
      // Repeated start keeps the location pointer
      next_state     = psu_mgmt_pkg::S_ADDR;
      next_bitCnt    = 4'h0;
      next_wrPending = 1'b0;
      next_sdaDriveN = 1'b1;
      next_sclDriveN = 1'b1;
    end else if (stop) begin
      // Write lands only on Stop, then busy for programming
      if (wrPending && !wpActive) begin
        commit       = 1'b1;
        next_progCnt = PW'(PROG_CYC);
      end
      next_wrPending = 1'b0;
      next_state     = psu_mgmt_pkg::S_IDLE;
      next_sdaDriveN = 1'b1;
      next_sclDriveN = 1'b1;
    end else if (lowCnt == TW'(TIMEOUT_CYC - 1)) begin
      // Abandon at once; recovery is a single cycle
      next_state     = psu_mgmt_pkg::S_IDLE;
      next_wrPending = 1'b0;
      next_sdaDriveN = 1'b1;
      next_sclDriveN = 1'b1;
    end else if (sclRise) begin
      case (state)
        psu_mgmt_pkg::S_ADDR, psu_mgmt_pkg::S_RX: begin
          next_shiftIn = {shiftIn[6:0], pins.sda};
          next_bitCnt  = bitCnt + 1'b1;
        end
        psu_mgmt_pkg::S_TXACK: begin
          if (pins.sda) begin
            next_state = psu_mgmt_pkg::S_IGNORE;
          end
        end
        default: ;
      endcase
    end else if (sclFall) begin
      case (state)
        psu_mgmt_pkg::S_ADDR: begin
          if (bitCnt == 4'h8) begin
            // Upper seven bits address, bit 0 direction
            next_rw      = shiftIn[0];
            next_byteIdx = 2'h0;
            next_target  = psu_mgmt_pkg::TGT_NONE;
            if (!addrSampled) begin
              next_target = psu_mgmt_pkg::TGT_NONE;
            end else if (shiftIn[7:1] == ctrlAddr[7:1]) begin
              next_target = psu_mgmt_pkg::TGT_CTRL;
            end else if (shiftIn[7:1] == eepAddr[7:1] && !progBusy) begin
              // Busy memory ignores the host
              next_target = psu_mgmt_pkg::TGT_EEP;
            end else if (shiftIn == `ARA_BYTE && (evShut || evWarn ||
                         faultLatched)) begin
              next_target = psu_mgmt_pkg::TGT_ARA;
            end
            // Own addresses once the strap is sampled (memory only when not busy), and the alert response byte while an alert is up, are acknowledged
            if (next_target == psu_mgmt_pkg::TGT_NONE) begin
              next_state = psu_mgmt_pkg::S_IGNORE;
            end else begin
              next_state     = psu_mgmt_pkg::S_ACK;
              next_sdaDriveN = 1'b0;
            end
          end
        end
        psu_mgmt_pkg::S_RX: begin
          if (bitCnt == 4'h8) begin
            next_state     = psu_mgmt_pkg::S_ACK;
            next_sdaDriveN = 1'b0;
            if (byteIdx != 2'h2) begin
              next_byteIdx = byteIdx + 1'b1;
            end
            if (target == psu_mgmt_pkg::TGT_CTRL && byteIdx == 2'h0) begin
              // Protection lifted only by its own command
              if (shiftIn == `CMD_WP_OFF) begin
                next_wpActive = 1'b0;
              end else if (shiftIn == `CMD_WP_ON) begin
                next_wpActive = 1'b1;
              end
            end else if (target == psu_mgmt_pkg::TGT_EEP) begin
              if (byteIdx == 2'h0) begin
                next_pointer = shiftIn[AW-1:0];
              end else if (byteIdx == 2'h1) begin
                next_wrData    = shiftIn;
                next_wrPending = 1'b1;
              end else begin
                // Page writes refused; single byte only
                next_state     = psu_mgmt_pkg::S_IGNORE;
                next_sdaDriveN = 1'b1;
              end
            end
          end
        end
        psu_mgmt_pkg::S_ACK, psu_mgmt_pkg::S_TXACK: begin
          next_sdaDriveN = 1'b1;
          next_bitCnt    = 4'h0;
          if (rw) begin
            next_state      = psu_mgmt_pkg::S_TX;
            next_txShift    = {rdByte[6:0], 1'b0};
            next_sdaDriveN  = rdByte[7];
            next_bitCnt     = 4'h1;
            next_sclDriveN  = 1'b0;
            next_stretchCnt = 4'h0;
            if (target == psu_mgmt_pkg::TGT_EEP) begin
              next_pointer = pointer + 1'b1;
            end
          end else begin
            next_state = psu_mgmt_pkg::S_RX;
          end
        end
        psu_mgmt_pkg::S_TX: begin
          if (bitCnt == 4'h8) begin
            next_state     = psu_mgmt_pkg::S_TXACK;
            next_sdaDriveN = 1'b1;
          end else begin
            next_sdaDriveN = txShift[7];
            next_txShift   = {txShift[6:0], 1'b0};
            next_bitCnt    = bitCnt + 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Never drives the clock except to stretch; no own transfers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state      <= psu_mgmt_pkg::S_IDLE;
      target     <= psu_mgmt_pkg::TGT_NONE;
      bitCnt     <= 4'h0;
      shiftIn    <= 8'h00;
      txShift    <= 8'h00;
      wrData     <= 8'h00;
      pointer    <= '0;
      byteIdx    <= 2'h0;
      rw         <= 1'b0;
      wrPending  <= 1'b0;
      wpActive   <= `WP_RESET;
      sdaDriveN  <= 1'b1;
      sclDriveN  <= 1'b1;
      stretchCnt <= 4'h0;
      lowCnt     <= '0;
      progCnt    <= '0;
      sclPrev    <= 1'b0;
      sdaPrev    <= 1'b0;
      sclOut     <= 1'b0;
      sdaOut     <= 1'b0;
    end else begin
      state      <= next_state;
      target     <= next_target;
      bitCnt     <= next_bitCnt;
      shiftIn    <= next_shiftIn;
      txShift    <= next_txShift;
      wrData     <= next_wrData;
      pointer    <= next_pointer;
      byteIdx    <= next_byteIdx;
      rw         <= next_rw;
      wrPending  <= next_wrPending;
      wpActive   <= next_wpActive;
      sdaDriveN  <= next_sdaDriveN;
      sclDriveN  <= next_sclDriveN;
      stretchCnt <= next_stretchCnt;
      lowCnt     <= next_lowCnt;
      progCnt    <= next_progCnt;
      sclPrev    <= pins.scl;
      sdaPrev    <= pins.sda;
      sclOut     <= 1'b0;
      sdaOut     <= 1'b0;
    end
  end

  // User memory; the supply itself never reads it
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      mem[pointer] <= wrData;
    end
  end

  // ----------------------------------------
  // Supply control and address strap
  // ----------------------------------------
  always_comb begin
    next_sampleCnt   = sampleCnt;
    next_addrSel     = addrSel;
    next_addrSampled = addrSampled;
    // Wait for the synchroniser to fill, then capture once
    if (!addrSampled) begin
      next_sampleCnt = sampleCnt + 1'b1;
      if (sampleCnt == 2'h3) begin
        next_addrSel     = pins.sel; // open pin reads as 3
        next_addrSampled = 1'b1;
      end
    end
    // New shutdown wins over a clear in the same cycle
    if (evShut) begin
      next_faultLatched = 1'b1;
    end else if (onReqPrev && !pins.onReqN) begin
      next_faultLatched = 1'b0;
    end else begin
      next_faultLatched = faultLatched;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sampleCnt    <= 2'h0;
      addrSel      <= `ADDR_SEL_OPEN;
      addrSampled  <= 1'b0;
      faultLatched <= 1'b0;
      onReqPrev    <= 1'b1;
      mainOutput   <= 1'b0;
      faultAlertN  <= 1'b1;
    end else begin
      sampleCnt    <= next_sampleCnt;
      addrSel      <= next_addrSel;
      addrSampled  <= next_addrSampled;
      faultLatched <= next_faultLatched;
      onReqPrev    <= pins.onReqN;
      mainOutput   <= ~pins.onReqN & (addrSampled | sampleCnt[1]);
      faultAlertN  <= ~(evShut | evWarn | faultLatched);
    end
  end

  // ----------------------------------------
  // APB slave, answers in the first access cycle
  // ----------------------------------------
  always_comb begin
    rdMux  = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `REG_CTRL) begin
      rdMux[1:0] = ctrl;
    end else if (paddr == `REG_STATUS) begin
      rdMux[`ST_MAIN_BIT]    = mainOutput;
      rdMux[`ST_FAULT_BIT]   = faultLatched;
      rdMux[`ST_WP_BIT]      = wpActive;
      rdMux[`ST_SEL_LSB+:2]  = addrSel;
      rdMux[`ST_BUSY_BIT]    = progBusy;
      rdMux[`ST_SAMPLED_BIT] = addrSampled;
    end else if (paddr == `REG_ALERT) begin
      rdMux[7:0] = statusByte;
    end else begin
      mapped = 1'b0;
    end
    next_pready  = psel & ~penable;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    next_ctrl    = ctrl;
    if (psel && !penable) begin
      next_prdata  = pwrite ? 32'h0000_0000 : rdMux;
      next_pslverr = ~mapped;
    end
    if (psel && penable && pready && pwrite && paddr == `REG_CTRL) begin
      next_ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      ctrl    <= `CTRL_RESET;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      ctrl    <= next_ctrl;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_reqCycle;
    pins.onReqN ##1 (!pins.onReqN && !evShut);
  endsequence
  property p_main_on;
    @(posedge clk_sys) disable iff (reset)
      (!outputOnRequestN)[*4] |-> mainOutput;
  endproperty
  a_main_on: assert property (p_main_on)
    else $error("main output off while requested");
  property p_main_off;
    @(posedge clk_sys) disable iff (reset)
      (outputOnRequestN)[*4] |-> !mainOutput;
  endproperty
  a_main_off: assert property (p_main_off)
    else $error("main output on while not requested");
  property p_fault_clear;
    @(posedge clk_sys) disable iff (reset)
      s_reqCycle |=> !faultLatched;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault not cleared by request cycle");
  property p_idle_quiet;
    @(posedge clk_sys) disable iff (reset)
      (state == psu_mgmt_pkg::S_IDLE) ##1
      (state == psu_mgmt_pkg::S_IDLE) |-> sdaDriveN && sclDriveN;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("bus driven while idle");
  property p_stretch;
    @(posedge clk_sys) disable iff (reset)
      $fell(sclDriveN) |-> ##[1:STR_BOUND] sclDriveN;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock stretch too long");
  property p_timeout;
    @(posedge clk_sys) disable iff (reset)
      (lowCnt == TW'(TIMEOUT_CYC - 1) && !start && !stop) |=>
      (state == psu_mgmt_pkg::S_IDLE && sdaDriveN && sclDriveN);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not release bus");
  property p_start;
    @(posedge clk_sys) disable iff (reset)
      start |=> (state == psu_mgmt_pkg::S_ADDR && bitCnt == 4'h0);
  endproperty
  a_start: assert property (p_start)
    else $error("start not recognised");
  property p_alert;
    @(posedge clk_sys) disable iff (reset)
      (evShut || evWarn) |=> !faultAlertN;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert not raised on event");
  property p_pair;
    @(posedge clk_sys) disable iff (reset)
      addrSampled && $past(addrSampled) |->
      (ctrlAddr - eepAddr == 8'h10) && $stable(addrSel);
  endproperty
  a_pair: assert property (p_pair)
    else $error("address pair broken or changed");
  property p_wp;
    @(posedge clk_sys) disable iff (reset)
      commit |-> !wpActive ##1 progBusy;
  endproperty
  a_wp: assert property (p_wp)
    else $error("write while protected");
  property p_nack;
    @(posedge clk_sys) disable iff (reset)
      (state == psu_mgmt_pkg::S_ADDR && sclFall && bitCnt == 4'h8 &&
       !start && !stop && shiftIn[7:1] != ctrlAddr[7:1] &&
       shiftIn[7:1] != eepAddr[7:1] && shiftIn != `ARA_BYTE) |=>
      (sdaDriveN && state == psu_mgmt_pkg::S_IGNORE);
  endproperty
  a_nack: assert property (p_nack)
    else $error("foreign address acknowledged");
endmodule : psu_mgmt_port
